// ==== rtl/bus_interface_end.sv ====
// Bus interface end: arbitration, strobes and routing to memories
`timescale 1ns/100ps
`include "local_bus_defs.svh"
module bus_interface_end
  import local_bus_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  local_bus_if.bus_interface bus,
  input wire logic hold_a,
  input wire logic hold_b,
  input wire logic hold_x,
  output logic [`LB_ADDR_W-1:0] mem_addr,
  output logic [`LB_DATA_W-1:0] mem_wdata_a,
  output logic [`LB_DATA_W-1:0] mem_wdata_b,
  input wire logic [`LB_DATA_W-1:0] mem_rdata_a,
  input wire logic [`LB_DATA_W-1:0] mem_rdata_b,
  input wire logic [`LB_DATA_W-1:0] flash_rdata,
  output logic chip_en_a_n,
  output logic chip_en_b_n,
  output logic chip_en_flash_n,
  output logic out_en_a_n,
  output logic out_en_b_n,
  output logic [`LB_LANES-1:0] write_strobe_a_n,
  output logic [`LB_LANES-1:0] write_strobe_b_n,
  output logic write_strobe_flash_n,
  output logic [`LB_DATA_W-1:0] isr_value
);
  slave_state_type st;
  slave_state_type next_st;
  logic sel_a;
  logic sel_b;
  logic sel_v;
  logic wr_a;
  logic wr_b;
  logic flash_acc;
  logic bank_a_acc;
  logic [`LB_LANES-1:0] lane_on;
  logic [`LB_DATA_W-1:0] src_a;

  // ****************************************
  // Decode of select and write levels
  // ****************************************
  assign sel_a = !bus.select_bank_a_n;
  assign sel_b = !bus.select_bank_b_n;
  assign sel_v = !bus.select_interface_n;
  assign wr_a = !bus.bank_a_write_n;
  assign wr_b = !bus.bank_b_write_n;
  assign flash_acc = sel_a && sel_v;
  assign bank_a_acc = sel_a && !sel_v;

  // Lane i covers data bits 8i+7..8i, lane 0 the lowest lines
  genvar i;
  generate
    for (i = 0; i < `LB_LANES; i++) begin : g_lane
      assign lane_on[i] = !bus.byte_lane_enable_n[i];
      assign write_strobe_a_n[i] = !(bank_a_acc && wr_a && lane_on[i]);
      assign write_strobe_b_n[i] = !(sel_b && wr_b && lane_on[i]);
    end
  endgenerate

  // ****************************************
  // Memory side routing
  // ****************************************
  assign mem_addr = bus.local_word_address;
  assign src_a = flash_acc ? flash_rdata : mem_rdata_a;
  assign mem_wdata_a = bus.local_data_lines;
  // Bank B takes bank A or flash data in a copy, else the local lines
  assign mem_wdata_b = (sel_a && !wr_a) ? src_a : bus.local_data_lines;
  assign write_strobe_flash_n = !(flash_acc && wr_a && (|lane_on));
  assign chip_en_a_n = !bank_a_acc;
  assign chip_en_flash_n = !flash_acc;
  assign chip_en_b_n = !sel_b;
  // Output enables follow a select with its write level high
  assign out_en_a_n = !(sel_a && !wr_a);
  assign out_en_b_n = !(sel_b && !wr_b);

  // ****************************************
  // Arbitration and local read path
  // ****************************************
  always_comb begin
    next_st = st;
    // A request for bank A or B also claims the logic bus
    next_st.grant_a = !bus.bank_a_bus_request_n && (st.grant_a || !hold_a);
    next_st.grant_b = !bus.bank_b_bus_request_n && (st.grant_b || !hold_b);
    next_st.grant_x = (!bus.logic_bus_request_n || !bus.bank_a_bus_request_n
                       || !bus.bank_b_bus_request_n) && (st.grant_x || !hold_x);
    next_st.sel_v_prev_n = bus.select_interface_n;
    // Interrupt service register takes data on the strobe leading edge
    if (sel_v && !sel_a && !sel_b && wr_a && st.sel_v_prev_n) begin
      next_st.isr = bus.local_data_lines;
    end
    // Read data returned one cycle after the select, when nothing is written
    next_st.data_oe = 1'b0;
    next_st.rdata = '0;
    if (sel_v && !sel_a && !sel_b && !wr_a) begin
      next_st.rdata = st.isr;
      next_st.data_oe = 1'b1;
    end else if (sel_a && !sel_b && !wr_a) begin
      next_st.rdata = src_a;
      next_st.data_oe = 1'b1;
    end else if (sel_b && !sel_a && !sel_v && !wr_b) begin
      next_st.rdata = mem_rdata_b;
      next_st.data_oe = 1'b1;
    end
    if (!st.grant_x) begin
      next_st.data_oe = 1'b0;
    end
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st.grant_a <= 1'b0;
      st.grant_b <= 1'b0;
      st.grant_x <= 1'b0;
      st.sel_v_prev_n <= 1'b1;
      st.isr <= `LB_ISR_RESET;
      st.rdata <= '0;
      st.data_oe <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  assign bus.bank_a_bus_grant = st.grant_a;
  assign bus.bank_b_bus_grant = st.grant_b;
  assign bus.logic_bus_grant = st.grant_x;
  assign bus.slave_data_out = st.rdata;
  assign bus.slave_data_oe = st.data_oe;
  assign isr_value = st.isr;
endmodule // bus_interface_end

// ==== rtl/local_bus_defs.svh ====
// Constants shared by both ends of the local bus access port
`ifndef LOCAL_BUS_DEFS_SVH
`define LOCAL_BUS_DEFS_SVH
// ****************************************
// Bus geometry
// ****************************************
`define LB_ADDR_LSB 2
`define LB_ADDR_MSB 20
`define LB_ADDR_W 19
`define LB_DATA_W 32
`define LB_LANES 4
`define LB_LANE_W 8
// ****************************************
// Timing counts in core_clk cycles, and the write buffer depth in words
// ****************************************
`define LB_SETUP_CYCLES 2
`define LB_READ_WAIT 2
`define LB_FIFO_DEPTH 16
// ****************************************
// Reset values
// ****************************************
`define LB_ISR_RESET 32'h0000_0000
`endif

// ==== rtl/local_bus_if.sv ====
// Interface joining the user logic and the bus interface logic
`timescale 1ns/100ps
`include "local_bus_defs.svh"
interface local_bus_if;
  logic [`LB_ADDR_W-1:0] addr_out;
  logic addr_oe;
  logic [`LB_ADDR_W-1:0] local_word_address;
  logic [`LB_DATA_W-1:0] master_data_out;
  logic master_data_oe;
  logic [`LB_DATA_W-1:0] slave_data_out;
  logic slave_data_oe;
  logic [`LB_DATA_W-1:0] local_data_lines;
  logic [`LB_LANES-1:0] byte_lane_enable_n;
  logic bank_a_write_n;
  logic bank_b_write_n;
  logic select_bank_a_n;
  logic select_bank_b_n;
  logic select_interface_n;
  logic logic_bus_request_n;
  logic bank_a_bus_request_n;
  logic bank_b_bus_request_n;
  logic logic_bus_grant;
  logic bank_a_bus_grant;
  logic bank_b_bus_grant;

  // Wire level of the shared lines from the drive enables
  assign local_word_address = addr_oe ? addr_out : '0;
  assign local_data_lines = master_data_oe ? master_data_out :
                            (slave_data_oe ? slave_data_out : '0);

  modport user_logic (
    output addr_out, addr_oe, master_data_out, master_data_oe,
    output byte_lane_enable_n, bank_a_write_n, bank_b_write_n,
    output select_bank_a_n, select_bank_b_n, select_interface_n,
    output logic_bus_request_n, bank_a_bus_request_n, bank_b_bus_request_n,
    input local_word_address, local_data_lines,
    input logic_bus_grant, bank_a_bus_grant, bank_b_bus_grant
  );
  modport bus_interface (
    output slave_data_out, slave_data_oe,
    output logic_bus_grant, bank_a_bus_grant, bank_b_bus_grant,
    input local_word_address, local_data_lines, byte_lane_enable_n,
    input bank_a_write_n, bank_b_write_n,
    input select_bank_a_n, select_bank_b_n, select_interface_n,
    input logic_bus_request_n, bank_a_bus_request_n, bank_b_bus_request_n
  );
endinterface // local_bus_if

// ==== rtl/local_bus_pkg.sv ====
// Types shared by both ends of the local bus access port
`include "local_bus_defs.svh"
package local_bus_pkg;
  // Target of one access, mapped to select line combinations
  typedef enum logic [2:0] {
    tgt_bank_a,
    tgt_bank_b,
    tgt_interface,
    tgt_flash,
    tgt_dual_ab
  } target_type;

  typedef enum logic [2:0] {
    st_idle,
    st_request,
    st_setup,
    st_strobe,
    st_read_wait,
    st_release
  } master_phase_type;

  // One buffered write word
  typedef struct packed {
    target_type target;
    logic [`LB_LANES-1:0] byte_en;
    logic [`LB_ADDR_W-1:0] addr;
    logic [`LB_DATA_W-1:0] data;
  } write_entry_type;

  typedef struct packed {
    master_phase_type phase;
    logic is_write;
    target_type target;
    logic [1:0] count;
    logic [`LB_ADDR_W-1:0] addr;
    logic [`LB_DATA_W-1:0] data;
    logic [`LB_LANES-1:0] byte_en_n;
    logic addr_oe;
    logic data_oe;
    logic write_a_n;
    logic write_b_n;
    logic sel_a_n;
    logic sel_b_n;
    logic sel_v_n;
    logic req_a_n;
    logic req_b_n;
    logic req_x_n;
    logic [`LB_DATA_W-1:0] rd_data;
    logic rd_data_valid;
  } master_state_type;

  typedef struct packed {
    logic grant_a;
    logic grant_b;
    logic grant_x;
    logic sel_v_prev_n;
    logic [`LB_DATA_W-1:0] isr;
    logic [`LB_DATA_W-1:0] rdata;
    logic data_oe;
  } slave_state_type;
endpackage

// ==== rtl/user_logic_end.sv ====
// User logic end: write buffer and local bus master sequencer
//
// Function
// - Address carries word bits 2 to 20
// - Data path is 32 bits, both ways
// - Four active-low byte enables pick bytes
// - Enable 0 covers lowest data lines
// - Full words may hold enables low
// - Interface qualifies enables with selects
// - Bank A write level low for A/interface/flash
// - Bank B write level low; both allowed
// - Write levels held through a block
// - Selects active low, strobe or enable
// - Strobe only after address settles
// - Strobe one cycle, two after setup
// - Block write advances every three cycles
// - Interface strobes only enabled lanes; flash strobes on any lane, ISR takes the whole word
// - Read select with first address held
// - Output enables on select, write high
// - Only valid select combinations used
// - A with B, and A B interface valid
// - Flash uses A plus interface select
// - Request, await grant, release when done
// - Address drivers only under logic grant
`timescale 1ns/100ps
`include "local_bus_defs.svh"

// ****************************************
// Write word buffer
// ****************************************
module word_fifo #(
  parameter int WIDTH = 58,
  parameter int DEPTH = `LB_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
  } fifo_state_type;
  fifo_state_type st;
  fifo_state_type next_st;
  logic [WIDTH-1:0] store [DEPTH];
  logic push;
  logic pop;

  assign in_ready = (st.count != DEPTH[PW:0]);
  assign out_valid = (st.count != '0);
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = store[st.rd_ptr];

  // Pointer and fill count update
  always_comb begin
    next_st = st;
    if (push) begin
      next_st.wr_ptr = st.wr_ptr + 1'b1;
    end
    if (pop) begin
      next_st.rd_ptr = st.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      next_st.count = st.count + 1'b1;
    end else if (pop && !push) begin
      next_st.count = st.count - 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Storage array write port
  always_ff @(posedge core_clk) begin
    if (push) begin
      store[st.wr_ptr] <= in_data;
    end
  end
endmodule // word_fifo

// ****************************************
// Local bus master
// ****************************************
module user_logic_end
  import local_bus_pkg::*;
#(
  parameter int FIFO_DEPTH = `LB_FIFO_DEPTH
) (
  input wire logic core_clk,
  input wire logic srst,
  local_bus_if.user_logic bus,
  input wire logic wr_valid,
  output logic wr_ready,
  input wire target_type wr_target,
  input wire logic [`LB_ADDR_W-1:0] wr_addr,
  input wire logic [`LB_DATA_W-1:0] wr_data,
  input wire logic [`LB_LANES-1:0] wr_byte_en,
  input wire logic rd_valid,
  output logic rd_ready,
  input wire target_type rd_target,
  input wire logic [`LB_ADDR_W-1:0] rd_addr,
  output logic [`LB_DATA_W-1:0] rd_data,
  output logic rd_data_valid,
  output logic busy
);
  master_state_type st;
  master_state_type next_st;
  write_entry_type in_entry;
  write_entry_type head;
  logic head_valid;
  logic head_pop;
  logic granted;

  assign in_entry = '{target: wr_target, byte_en: wr_byte_en, addr: wr_addr,
                      data: wr_data};

  word_fifo #(
    .WIDTH($bits(write_entry_type)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .core_clk(core_clk),
    .srst(srst),
    .in_valid(wr_valid),
    .in_ready(wr_ready),
    .in_data(in_entry),
    .out_valid(head_valid),
    .out_ready(head_pop),
    .out_data(head)
  );

  // Select lines per target, active high
  function automatic logic [2:0] sel_of(input target_type t);
    case (t)
      tgt_bank_a: sel_of = 3'h4;
      tgt_bank_b: sel_of = 3'h2;
      tgt_interface: sel_of = 3'h1;
      tgt_flash: sel_of = 3'h5;
      tgt_dual_ab: sel_of = 3'h6;
      default: sel_of = 3'h0;
    endcase
  endfunction

  // Grant check: the logic bus always, banks as the target needs
  assign granted = bus.logic_bus_grant
                   && (st.req_a_n || bus.bank_a_bus_grant)
                   && (st.req_b_n || bus.bank_b_bus_grant);

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    logic [2:0] sel;
    sel = sel_of(st.target);
    next_st = st;
    next_st.rd_data_valid = 1'b0;
    head_pop = 1'b0;
    case (st.phase)
      st_idle: begin
        if (head_valid) begin
          next_st.is_write = 1'b1;
          next_st.target = head.target;
          next_st.phase = st_request;
        end else if (rd_valid) begin
          next_st.is_write = 1'b0;
          next_st.target = rd_target;
          next_st.addr = rd_addr;
          next_st.phase = st_request;
        end
        sel = sel_of(next_st.target);
        if (next_st.phase == st_request) begin
          next_st.req_a_n = !sel[2];
          next_st.req_b_n = !sel[1];
          next_st.req_x_n = 1'b0;
        end
      end
      st_request: begin
        if (granted && st.is_write) begin
          head_pop = 1'b1;
          next_st.addr = head.addr;
          next_st.data = head.data;
          next_st.byte_en_n = ~head.byte_en;
          next_st.addr_oe = 1'b1;
          next_st.data_oe = 1'b1;
          next_st.write_a_n = !(sel[2] || sel[0]);
          next_st.write_b_n = !sel[1];
          next_st.count = '0;
          next_st.phase = st_setup;
        end else if (granted) begin
          next_st.byte_en_n = '0;
          next_st.addr_oe = 1'b1;
          next_st.sel_a_n = !sel[2];
          next_st.sel_b_n = !sel[1];
          next_st.sel_v_n = !sel[0];
          next_st.count = '0;
          next_st.phase = st_read_wait;
        end
      end
      st_setup: begin
        // Address and data settle before the strobe
        if (st.count == 2'(`LB_SETUP_CYCLES - 1)) begin
          next_st.sel_a_n = !sel[2];
          next_st.sel_b_n = !sel[1];
          next_st.sel_v_n = !sel[0];
          next_st.phase = st_strobe;
        end else begin
          next_st.count = st.count + 1'b1;
        end
      end
      st_strobe: begin
        next_st.sel_a_n = 1'b1;
        next_st.sel_b_n = 1'b1;
        next_st.sel_v_n = 1'b1;
        // Same target keeps the write levels and continues the block
        if (head_valid && head.target == st.target) begin
          head_pop = 1'b1;
          next_st.addr = head.addr;
          next_st.data = head.data;
          next_st.byte_en_n = ~head.byte_en;
          next_st.count = '0;
          next_st.phase = st_setup;
        end else begin
          next_st.phase = st_release;
        end
      end
      st_read_wait: begin
        if (st.count == 2'(`LB_READ_WAIT - 1)) begin
          next_st.rd_data = bus.local_data_lines;
          next_st.rd_data_valid = 1'b1;
          next_st.phase = st_release;
        end else begin
          next_st.count = st.count + 1'b1;
        end
      end
      st_release: begin
        // Drop drivers, levels and requests together
        next_st.addr_oe = 1'b0;
        next_st.data_oe = 1'b0;
        next_st.write_a_n = 1'b1;
        next_st.write_b_n = 1'b1;
        next_st.sel_a_n = 1'b1;
        next_st.sel_b_n = 1'b1;
        next_st.sel_v_n = 1'b1;
        next_st.req_a_n = 1'b1;
        next_st.req_b_n = 1'b1;
        next_st.req_x_n = 1'b1;
        next_st.phase = st_idle;
      end
      default: begin
        next_st.phase = st_release;
      end
    endcase
  end

  // State register
  always_ff @(posedge core_clk) begin
    if (srst) begin
      st <= '0;
      st.phase <= st_idle;
      st.target <= tgt_bank_a;
      st.write_a_n <= 1'b1;
      st.write_b_n <= 1'b1;
      st.sel_a_n <= 1'b1;
      st.sel_b_n <= 1'b1;
      st.sel_v_n <= 1'b1;
      st.req_a_n <= 1'b1;
      st.req_b_n <= 1'b1;
      st.req_x_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Pin drive
  // ****************************************
  assign bus.addr_out = st.addr;
  assign bus.addr_oe = st.addr_oe && bus.logic_bus_grant;
  assign bus.master_data_out = st.data;
  assign bus.master_data_oe = st.data_oe && bus.logic_bus_grant;
  assign bus.byte_lane_enable_n = st.byte_en_n;
  assign bus.bank_a_write_n = st.write_a_n;
  assign bus.bank_b_write_n = st.write_b_n;
  assign bus.select_bank_a_n = st.sel_a_n;
  assign bus.select_bank_b_n = st.sel_b_n;
  assign bus.select_interface_n = st.sel_v_n;
  assign bus.bank_a_bus_request_n = st.req_a_n;
  assign bus.bank_b_bus_request_n = st.req_b_n;
  assign bus.logic_bus_request_n = st.req_x_n;
  assign rd_ready = (st.phase == st_idle) && !head_valid;
  assign rd_data = st.rd_data;
  assign rd_data_valid = st.rd_data_valid;
  assign busy = (st.phase != st_idle);
endmodule // user_logic_end

// ==== test/local_bus_props.sv ====
// Concurrent checks on the local bus between the two ends
`timescale 1ns/100ps
`include "local_bus_defs.svh"
module local_bus_props (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic addr_oe,
  input wire logic master_data_oe,
  input wire logic slave_data_oe,
  input wire logic [`LB_ADDR_W-1:0] local_word_address,
  input wire logic bank_a_write_n,
  input wire logic bank_b_write_n,
  input wire logic select_bank_a_n,
  input wire logic select_bank_b_n,
  input wire logic select_interface_n,
  input wire logic logic_bus_request_n,
  input wire logic bank_a_bus_request_n,
  input wire logic bank_b_bus_request_n,
  input wire logic logic_bus_grant
);
  // Helper levels built from the bus lines
  wire any_sel = !(select_bank_a_n && select_bank_b_n && select_interface_n);
  wire write_on = !bank_a_write_n || !bank_b_write_n;
  wire any_req = !(logic_bus_request_n && bank_a_bus_request_n && bank_b_bus_request_n);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // ****************************************
  // Steps of a transfer
  // ****************************************
  sequence strobe_start;
    $rose(any_sel) && write_on;
  endsequence
  sequence read_start;
    $rose(any_sel) && !write_on;
  endsequence
  // ****************************************
  // Ownership, drive and select combinations
  // ****************************************
  chk_addr_grant: assert property (addr_oe |-> logic_bus_grant && !logic_bus_request_n)
    else $error("address driven without bus grant");
  chk_data_write: assert property (master_data_oe |->
    logic_bus_grant && write_on && !slave_data_oe)
    else $error("data lines driven outside a granted write");
  chk_slave_read: assert property (slave_data_oe |-> logic_bus_grant && !write_on)
    else $error("read data driven outside a granted read");
  chk_sel_grant: assert property (any_sel |-> logic_bus_grant)
    else $error("select asserted without bus grant");
  chk_grant_cause: assert property ($rose(logic_bus_grant) |-> $past(any_req))
    else $error("grant rose without a request");
  chk_grant_release: assert property (!any_req |=> !logic_bus_grant)
    else $error("grant held after requests dropped");
  chk_valid_combo: assert property (any_sel |->
    !(select_bank_a_n && !select_bank_b_n && !select_interface_n))
    else $error("invalid select combination");
  // ****************************************
  // Write and read timing
  // ****************************************
  chk_strobe_setup: assert property (strobe_start |->
    $past(addr_oe, 2) && $past(local_word_address, 2) == local_word_address)
    else $error("write strobe not two cycles after address");
  chk_strobe_pulse: assert property (strobe_start |=> !any_sel [*2])
    else $error("write strobe not a single cycle pulse");
  chk_write_level: assert property ($fell(bank_a_write_n) |-> !bank_a_write_n [*3])
    else $error("write level not held through the strobe");
  chk_read_select: assert property (read_start |-> addr_oe ##0 any_sel [*3])
    else $error("read select not held with address");
  chk_read_answer: assert property (read_start |=> slave_data_oe)
    else $error("no read data one cycle after select");
endmodule // local_bus_props

// ==== test/tb_top.sv ====
// Testbench joining the user logic end and the bus interface end
`timescale 1ns/100ps
`include "local_bus_defs.svh"
module tb_top import local_bus_pkg::*;;
  logic core_clk, srst, wr_valid, wr_ready, rd_valid, rd_ready, rd_data_valid, busy;
  logic hold_a, hold_b, hold_x, chip_en_a_n, chip_en_b_n, chip_en_flash_n;
  logic out_en_a_n, out_en_b_n, write_strobe_flash_n;
  target_type wr_target, rd_target;
  logic [18:0] wr_addr, rd_addr, mem_addr;
  logic [31:0] wr_data, rd_data, mem_wdata_a, mem_wdata_b, mem_rdata_a, mem_rdata_b;
  logic [31:0] flash_rdata, isr_value;
  logic [3:0] wr_byte_en, write_strobe_a_n, write_strobe_b_n;
  bit [31:0] mem_a [256];
  bit [31:0] mem_b [256];
  bit [31:0] mem_f [256];
  int num_errors, total_checks, i, taken;
  target_type tgts [4] = '{tgt_bank_a, tgt_bank_b, tgt_flash, tgt_interface};
  logic [31:0] words [4] = '{32'h1234_5678, 32'h9ABC_DEF0, 32'h0F1E_2D3C, 32'hA5C3_5A3C};

  local_bus_if bus_link ();
  user_logic_end user_logic_end_inst (.core_clk(core_clk), .srst(srst), .bus(bus_link),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_target(wr_target), .wr_addr(wr_addr),
    .wr_data(wr_data), .wr_byte_en(wr_byte_en), .rd_valid(rd_valid), .rd_ready(rd_ready),
    .rd_target(rd_target), .rd_addr(rd_addr), .rd_data(rd_data),
    .rd_data_valid(rd_data_valid), .busy(busy));
  bus_interface_end bus_interface_end_inst (.core_clk(core_clk), .srst(srst), .bus(bus_link),
    .hold_a(hold_a), .hold_b(hold_b), .hold_x(hold_x), .mem_addr(mem_addr),
    .mem_wdata_a(mem_wdata_a), .mem_wdata_b(mem_wdata_b), .mem_rdata_a(mem_rdata_a),
    .mem_rdata_b(mem_rdata_b), .flash_rdata(flash_rdata), .chip_en_a_n(chip_en_a_n),
    .chip_en_b_n(chip_en_b_n), .chip_en_flash_n(chip_en_flash_n), .out_en_a_n(out_en_a_n),
    .out_en_b_n(out_en_b_n), .write_strobe_a_n(write_strobe_a_n),
    .write_strobe_b_n(write_strobe_b_n), .write_strobe_flash_n(write_strobe_flash_n),
    .isr_value(isr_value));
  local_bus_props local_bus_props_inst (.core_clk(core_clk), .srst(srst),
    .addr_oe(bus_link.addr_oe), .master_data_oe(bus_link.master_data_oe),
    .slave_data_oe(bus_link.slave_data_oe), .local_word_address(bus_link.local_word_address),
    .bank_a_write_n(bus_link.bank_a_write_n), .bank_b_write_n(bus_link.bank_b_write_n),
    .select_bank_a_n(bus_link.select_bank_a_n), .select_bank_b_n(bus_link.select_bank_b_n),
    .select_interface_n(bus_link.select_interface_n),
    .logic_bus_request_n(bus_link.logic_bus_request_n),
    .bank_a_bus_request_n(bus_link.bank_a_bus_request_n),
    .bank_b_bus_request_n(bus_link.bank_b_bus_request_n),
    .logic_bus_grant(bus_link.logic_bus_grant));

  // Memories answer only when enabled; otherwise the lines show the inverse
  assign mem_rdata_a = (!chip_en_a_n && !out_en_a_n) ? mem_a[mem_addr[7:0]]
    : ~mem_a[mem_addr[7:0]];
  assign mem_rdata_b = (!chip_en_b_n && !out_en_b_n) ? mem_b[mem_addr[7:0]]
    : ~mem_b[mem_addr[7:0]];
  assign flash_rdata = (!chip_en_flash_n && !out_en_a_n) ? mem_f[mem_addr[7:0]]
    : ~mem_f[mem_addr[7:0]];

  // Byte-lane memory chips written by their own strobes, flash as a whole word
  always @(posedge core_clk) begin
    for (int k = 0; k < 4; k++) begin
      if (write_strobe_a_n[k] === 1'b0) mem_a[mem_addr[7:0]][8*k +: 8] <= mem_wdata_a[8*k +: 8];
      if (write_strobe_b_n[k] === 1'b0) mem_b[mem_addr[7:0]][8*k +: 8] <= mem_wdata_b[8*k +: 8];
    end
    if (write_strobe_flash_n === 1'b0) mem_f[mem_addr[7:0]] <= mem_wdata_a;
  end

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic results;
    if (num_errors == 0 && total_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask

  task automatic timed_out(input string name);
    num_errors++;
    $display("unexpected %s: expected done, seen timeout", name);
    results();
  endtask

  // Push one word; fields stay up until accepted
  task automatic push(input target_type t, input logic [18:0] a, input logic [31:0] d,
                      input logic [3:0] be);
    int n;
    wr_valid = 1'b1;
    wr_target = t;
    wr_addr = a;
    wr_data = d;
    wr_byte_en = be;
    for (n = 0; n < 400; n++) begin
      @(posedge core_clk);
      if (wr_ready === 1'b1) break;
    end
    #1;
    if (n == 400) timed_out("wr_ready");
  endtask

  // Wait until the master has stayed idle for three cycles
  task automatic wait_idle;
    int n, quiet;
    wr_valid = 1'b0;
    quiet = 0;
    for (n = 0; n < 2000 && quiet < 3; n++) begin
      @(posedge core_clk);
      #1;
      quiet = (busy === 1'b0) ? quiet + 1 : 0;
    end
    if (quiet < 3) timed_out("busy");
  endtask

  task automatic read_check(input string name, input target_type t, input logic [18:0] a,
                            input logic [31:0] exp);
    int n;
    rd_valid = 1'b1;
    rd_target = t;
    rd_addr = a;
    for (n = 0; n < 400; n++) begin
      @(posedge core_clk);
      if (rd_ready === 1'b1) break;
    end
    #1;
    rd_valid = 1'b0;
    if (n == 400) timed_out("rd_ready");
    for (n = 0; n < 400 && rd_data_valid !== 1'b1; n++) begin
      @(posedge core_clk);
      #1;
    end
    if (n == 400) timed_out("rd_data_valid");
    check(name, exp, rd_data);
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    num_errors = 0;
    total_checks = 0;
    srst = 1'b1;
    {wr_valid, rd_valid, hold_a, hold_b, hold_x} = '0;
    {wr_target, rd_target} = {tgt_bank_a, tgt_bank_a};
    {wr_addr, rd_addr, wr_data, wr_byte_en} = '0;
    repeat (5) @(posedge core_clk);
    #1;
    srst = 1'b0;
    check("grant after reset", 32'h0, {31'h0, bus_link.logic_bus_grant});
    // One full word to bank A, bank B, flash and the interface, then read each back
    for (i = 0; i < 4; i++) push(tgts[i], 19'(8 + i), words[i], 4'hF);
    wait_idle();
    check("isr_value", words[3], isr_value);
    for (i = 0; i < 4; i++) read_check("read back", tgts[i], 19'(8 + i), words[i]);
    // Partial write touches only the enabled lanes
    push(tgt_bank_a, 19'h20, 32'h1122_3344, 4'hF);
    push(tgt_bank_a, 19'h20, 32'hAABB_CCDD, 4'h5);
    wait_idle();
    read_check("byte lanes", tgt_bank_a, 19'h20, 32'h11BB_33DD);
    // Dual-bank write reaches both banks
    push(tgt_dual_ab, 19'h40, 32'hCAFE_F00D, 4'hF);
    wait_idle();
    read_check("dual bank a", tgt_bank_a, 19'h40, 32'hCAFE_F00D);
    read_check("dual bank b", tgt_bank_b, 19'h40, 32'hCAFE_F00D);
    // Fill the buffer while bank A is held by another master
    hold_a = 1'b1;
    taken = 0;
    wr_valid = 1'b1;
    wr_target = tgt_bank_a;
    wr_byte_en = 4'hF;
    for (i = 0; i < 24; i++) begin
      wr_addr = 19'(8'h80 + taken);
      wr_data = 32'hB000_0000 + taken;
      @(posedge core_clk);
      if (wr_ready !== 1'b1) break;
      taken++;
      #1;
    end
    #1;
    wr_valid = 1'b0;
    check("buffer refused", 32'h1, {31'h0, (taken >= 16 && taken <= 17)});
    check("stalled grant", 32'h0, {31'h0, bus_link.bank_a_bus_grant});
    hold_a = 1'b0;
    wait_idle();
    read_check("drain first", tgt_bank_a, 19'h80, 32'hB000_0000);
    read_check("drain last", tgt_bank_a, 19'(8'h80 + taken - 1), 32'hB000_0000 + taken - 1);
    results();
  end
endmodule // tb_top
